// File: rtl/sdg_consts.vh
/*
  Shared constants of the four-channel step and direction generator:
  register byte offsets, timing-field positions, reset values and timing.
  Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef SDG_CONSTS_VH
`define SDG_CONSTS_VH

// Clock and timing unit
`define SDG_CLK_NS 20
`define SDG_UNIT_NS 1600
`define SDG_UNIT_CYC (`SDG_UNIT_NS / `SDG_CLK_NS)
`define SDG_MAX_NS 49600
`define SDG_MAX_UNITS (`SDG_MAX_NS / `SDG_UNIT_NS)
`define SDG_TIME_W 5

// Register byte offsets
`define SDG_REG_TIMING 8'h00
`define SDG_REG_OUTPUTS 8'h04
`define SDG_REG_INPUTS 8'h08
`define SDG_REG_RATE0 8'h10
`define SDG_REG_POS0 8'h20
`define SDG_REG_BANK_MASK 8'hF0
`define SDG_CH_SEL_LSB 2

// Timing register fields
`define SDG_LEN_LSB 0
`define SDG_SPACE_LSB 8
`define SDG_DIR_LSB 16
`define SDG_ENABLE_BIT 31
`define SDG_TIMING_RESET 32'h00000000

// AHB-Lite codes
`define SDG_HRESP_OKAY 1'h0

`endif

// File: rtl/sdg_channel.v
/*
  One step and direction channel: a phase accumulator turns the signed rate
  word into step requests, a small state machine shapes each pulse and
  guards direction changes, and a counter tracks the emitted position.
  Assumes timing fields are held steady by the top level between writes.
*/
`timescale 1ns/1ns
`include "sdg_consts.vh"

module sdg_channel #(
  parameter TW = `SDG_TIME_W
) (
  input wire sysClk,
  input wire rst,
  input wire [31:0] rate,
  input wire [TW-1:0] stepLen,
  input wire [TW-1:0] stepSpace,
  input wire [TW-1:0] dirTime,
  output reg pulse_q,
  output reg way_q,
  output reg [31:0] pos_q
);

  localparam S_IDLE = 4'h1;
  localparam S_DIR = 4'h2;
  localparam S_HIGH = 4'h4;
  localparam S_LOW = 4'h8;

  reg [3:0] state_q;
  reg [11:0] cnt_q;
  reg [31:0] acc_q;
  reg pend_q;
  reg pendDir_q;
  wire [31:0] mag;
  wire [32:0] sum;
  wire take;

  // Units to cycles; zero counts as one unit so no phase can vanish
  function [11:0] cyc;
    input [TW-1:0] u;
    reg [31:0] w;
    begin
      w = (u == {TW{1'b0}}) ? 32'h00000001 : {{(32-TW){1'b0}}, u};
      w = w * `SDG_UNIT_CYC - 32'h00000001;
      cyc = w[11:0];
    end
  endfunction

  assign mag = rate[31] ? (~rate + 32'h00000001) : rate;
  assign sum = {1'b0, acc_q} + {1'b0, mag};
  assign take = state_q[0] && pend_q && (pendDir_q == way_q);

  // Accumulator carry requests one step; set wins over the take
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      acc_q <= 32'h00000000;
      pend_q <= 1'b0;
      pendDir_q <= 1'b0;
    end else begin
      acc_q <= sum[31:0];
      if (sum[32]) begin
        pend_q <= 1'b1;
        pendDir_q <= ~rate[31];
      end else if (take) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Pulse shaper: every phase lasts at least its programmed units
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 12'h000;
      pulse_q <= 1'b0;
      way_q <= 1'b0;
      pos_q <= 32'h00000000;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (pend_q && (pendDir_q != way_q)) begin
            way_q <= pendDir_q;
            cnt_q <= cyc(dirTime);
            state_q <= S_DIR;
          end else if (take) begin
            pulse_q <= 1'b1;
            cnt_q <= cyc(stepLen);
            pos_q <= way_q ? pos_q + 32'h00000001 : pos_q - 32'h00000001;
            state_q <= S_HIGH;
          end
        end
        S_DIR: begin
          if (cnt_q == 12'h000) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        S_HIGH: begin
          if (cnt_q == 12'h000) begin
            pulse_q <= 1'b0;
            // The idle cycle before the next take counts as part of the space,
            // so one unit high plus one unit low gives the full top step rate
            cnt_q <= cyc(stepSpace) - 12'h001;
            state_q <= S_LOW;
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        S_LOW: begin
          if (cnt_q == 12'h000) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        default: begin
          state_q <= S_IDLE;
          pulse_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // sdg_channel

// File: rtl/sdg_top.v
/*
  Four-channel step and direction generator with general-purpose inputs
  and outputs, programmed over an AHB-Lite slave with zero wait states.
  Assumes a single 50 MHz clock, inputs synchronous to it, and single
  whole-word transfers from the one bus master.
*/
// Design decisions made here: the address map and the AHB-Lite register port.
// Notes on behaviour
// - Four channels, step plus direction, 312.5 kHz
// - Pulse, space, direction times are host-programmed
// - Emitted waveform never shorter than programmed minimums
// - Times in 1.6 us units, at most 49.6
// - One timing set shared by all channels
// - Rate changes take effect per channel independently
// - All general outputs change in one update
// - All general inputs latched at one instant
// - Each channel position captured on its own
// - Fourteen general outputs, sixteen general inputs
// - All host traffic through the register link
// - Indicator shows channel zero step xor direction
`timescale 1ns/1ns
`include "sdg_consts.vh"

module sdg_top #(
  parameter NCH = 4,
  parameter NOUT = 14,
  parameter NIN = 16
) (
  input wire sysClk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [NIN-1:0] generalInput,
  output reg [NOUT-1:0] generalOutput,
  output wire [NCH-1:0] pulseOut,
  output wire [NCH-1:0] wayOut,
  output reg ledOut
);

  localparam TW = `SDG_TIME_W;

  reg [31:0] timing_q;
  reg [31:0] rate_q [0:NCH-1];
  reg wrPend_q;
  reg [7:0] wrAddr_q;
  wire [31:0] pos [0:NCH-1];
  wire addrPhase;
  wire [7:0] aOff;
  wire [1:0] aCh;
  wire [7:0] wBank;
  wire [1:0] wCh;
  wire [TW-1:0] stepLen;
  wire [TW-1:0] stepSpace;
  wire [TW-1:0] dirTime;
  wire enable;
  reg [31:0] rdMux;

  // Shared timing fields, one set for every channel
  assign stepLen = timing_q[`SDG_LEN_LSB +: TW];
  assign stepSpace = timing_q[`SDG_SPACE_LSB +: TW];
  assign dirTime = timing_q[`SDG_DIR_LSB +: TW];
  assign enable = timing_q[`SDG_ENABLE_BIT];

  // Address phase qualified by the bus-wide ready
  assign addrPhase = hsel && htrans[1] && hready;
  assign aOff = haddr[7:0];
  assign aCh = aOff[`SDG_CH_SEL_LSB +: 2];
  assign wBank = wrAddr_q & `SDG_REG_BANK_MASK;
  assign wCh = wrAddr_q[`SDG_CH_SEL_LSB +: 2];

  // Read mux; the value is taken at the address-phase edge
  always @* begin
    rdMux = 32'h00000000;
    if ((aOff & `SDG_REG_BANK_MASK) == `SDG_REG_RATE0) begin
      rdMux = rate_q[aCh];
    end else if ((aOff & `SDG_REG_BANK_MASK) == `SDG_REG_POS0) begin
      rdMux = pos[aCh];
    end else begin
      case (aOff)
        `SDG_REG_TIMING: rdMux = timing_q;
        `SDG_REG_OUTPUTS: rdMux = {{(32-NOUT){1'b0}}, generalOutput};
        `SDG_REG_INPUTS: rdMux = {{(32-NIN){1'b0}}, generalInput};
        default: rdMux = 32'h00000000;
      endcase
    end
  end

  // Bus slave: zero wait states, always OKAY, unmapped reads give zero
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `SDG_HRESP_OKAY;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `SDG_HRESP_OKAY;
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= aOff;
      end
      // The read word is the holding register: all inputs land on one edge
      if (addrPhase && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // Register writes land in the data phase
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      timing_q <= `SDG_TIMING_RESET;
      generalOutput <= {NOUT{1'b0}};
    end else if (wrPend_q) begin
      if (wrAddr_q == `SDG_REG_TIMING) begin
        timing_q <= hwdata;
      end
      if (wrAddr_q == `SDG_REG_OUTPUTS) begin
        generalOutput <= hwdata[NOUT-1:0];
      end
    end
  end

  // Per-channel rate registers and generators
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      always @(posedge sysClk or posedge rst) begin
        if (rst) begin
          rate_q[g] <= 32'h00000000;
        end else if (wrPend_q && wBank == `SDG_REG_RATE0 && wCh == g) begin
          rate_q[g] <= hwdata;
        end
      end

      sdg_channel #(
        .TW(TW)
      ) uChan (
        .sysClk(sysClk),
        .rst(rst),
        .rate(rate_q[g]),
        .stepLen(stepLen),
        .stepSpace(stepSpace),
        .dirTime(dirTime),
        .pulse_q(pulseOut[g]),
        .way_q(wayOut[g]),
        .pos_q(pos[g])
      );
    end
  endgenerate

  // Indicator follows channel zero once the enable bit is set
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      ledOut <= 1'b0;
    end else begin
      ledOut <= enable & (pulseOut[0] ^ wayOut[0]);
    end
  end

endmodule // sdg_top

// File: bench/sdg_checker.sv
/* Port checker for sdg_top.
   Assumes bind into sdg_top, one clock. */
`timescale 1ns/1ns
module sdg_checker (
  input wire sysClk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [13:0] generalOutput,
  input wire [3:0] pulseOut,
  input wire [3:0] wayOut,
  input wire ledOut
);
  reg [15:0] hiCnt, loCnt, wayCnt;
  reg wrOut_q;
  default clocking @(posedge sysClk); endclocking
  default disable iff (rst);
  // Channel zero run lengths; the low and turn counts saturate so a long idle never wraps
  always @(posedge sysClk or posedge rst) begin
    if (rst) begin
      {hiCnt, loCnt, wayCnt, wrOut_q} <= {16'h0000, 16'hFFFF, 16'hFFFF, 1'h0};
    end else begin
      hiCnt <= pulseOut[0] ? hiCnt + 16'h0001 : 16'h0000;
      loCnt <= pulseOut[0] ? 16'h0000 : loCnt + {15'h0000, ~&loCnt};
      wayCnt <= $changed(wayOut[0]) ? 16'h0000 : wayCnt + {15'h0000, ~&wayCnt};
      wrOut_q <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h04);
    end
  end
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_ok; !hresp; endproperty
  a_ok: assert property (p_ok) else $error("error reply");
  property p_hi; $fell(pulseOut[0]) |-> hiCnt >= 16'h0050; endproperty
  a_hi: assert property (p_hi) else $error("short pulse");
  property p_lo; $rose(pulseOut[0]) |-> loCnt >= 16'h0050; endproperty
  a_lo: assert property (p_lo) else $error("short space");
  property p_dir; $rose(pulseOut[0]) |-> wayCnt >= 16'h004F; endproperty
  a_dir: assert property (p_dir) else $error("step soon after turn");
  property p_turn; $changed(wayOut[0]) |-> !pulseOut[0] && !$past(pulseOut[0]); endproperty
  a_turn: assert property (p_turn) else $error("turn in pulse");
  property p_led; ledOut |-> $past(pulseOut[0]) != $past(wayOut[0]); endproperty
  a_led: assert property (p_led) else $error("led wrong");
  property p_out; $changed(generalOutput) |-> $past(wrOut_q); endproperty
  a_out: assert property (p_out) else $error("stray output");
endmodule // sdg_checker

// File: bench/sdg_host.sv
/* Host bus master model, single word transfers.
   Assumes hready is the slave's hreadyout. */
`timescale 1ns/1ns
module sdg_host (
  input wire sysClk,
  input wire hready,
  input wire [31:0] hrdata,
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata
);
  // Bus idle from time zero
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = 71'h0;
  // Address phase held until ready, then data phase held until ready
  task xfer(input reg w, input reg [31:0] a, input reg [31:0] d, output reg [31:0] q);
    begin
      {hsel, htrans, hwrite, hsize, haddr} <= {1'h1, 2'h2, w, 3'h2, a};
      do @(posedge sysClk); while (!hready);
      {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
      do @(posedge sysClk); while (!hready);
      q = hrdata;
    end
  endtask
endmodule // sdg_host

// File: bench/sdg_tb.sv
/* Bench: registers, general I/O, channel zero stepping.
   Assumes sdg_consts.vh on the include path. */
`timescale 1ns/1ns
`include "sdg_consts.vh"
module tb;
  reg sysClk;
  reg rst;
  reg [15:0] generalInput;
  wire hsel, hwrite, hreadyout, hresp, ledOut;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [13:0] generalOutput;
  wire [3:0] pulseOut, wayOut;
  integer errors, cmp_count, cycles, net, hiRun, lastHigh, others, ledSeen, gapRun, lastGap;
  reg [31:0] rdata;
  reg [3:0] pulsePrev;
  sdg_top uut (
    .sysClk(sysClk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .generalInput(generalInput),
    .generalOutput(generalOutput),
    .pulseOut(pulseOut),
    .wayOut(wayOut),
    .ledOut(ledOut)
  );
  sdg_host host (
    .sysClk(sysClk),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata)
  );
  initial begin
    sysClk = 1'h0;
    forever #10 sysClk = ~sysClk;
  end
  // Pin watch: step count, high run, other channels, LED, channel 2 period, hang limit
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    pulsePrev <= pulseOut;
    hiRun <= pulseOut[0] ? hiRun + 1 : 0;
    if (!pulseOut[0] && pulsePrev[0]) lastHigh <= hiRun;
    if (pulseOut[0] && !pulsePrev[0]) net <= wayOut[0] ? net + 1 : net - 1;
    if (|(pulseOut[3:1] & ~pulsePrev[3:1])) others <= others + 1;
    if (ledOut) ledSeen <= ledSeen + 1;
    gapRun <= (pulseOut[2] && !pulsePrev[2]) ? 1 : gapRun + 1;
    if (pulseOut[2] && !pulsePrev[2]) lastGap <= gapRun;
    if (cycles == 20000) begin
      errors = errors + 1;
      close_out;
    end
  end
  task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && cmp_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // Shared times: length 2, space 1, turn 1 (larger of setup and hold), LED on
  task t_regs;
    begin
      host.xfer(1'h1, `SDG_REG_TIMING, 32'h80010102, rdata);
      host.xfer(1'h0, `SDG_REG_TIMING, 32'h0, rdata);
      chk(rdata, 32'h80010102);
      host.xfer(1'h0, 32'h0000000C, 32'h0, rdata);
      chk(rdata, 32'h00000000);
    end
  endtask
  task t_io;
    begin
      host.xfer(1'h1, `SDG_REG_OUTPUTS, 32'hFFFFABCD, rdata);
      generalInput <= 16'hA5C3;
      host.xfer(1'h0, `SDG_REG_OUTPUTS, 32'h0, rdata);
      chk(rdata, 32'h00002BCD);
      chk({18'h0, generalOutput}, 32'h00002BCD);
      host.xfer(1'h0, `SDG_REG_INPUTS, 32'h0, rdata);
      chk(rdata, 32'h0000A5C3);
    end
  endtask
  // About one step per 400 cycles, then stop and read the position back
  task t_step(input reg [31:0] rate, input reg way);
    integer n0;
    begin
      n0 = net;
      host.xfer(1'h1, `SDG_REG_RATE0, rate, rdata);
      repeat (4000) @(posedge sysClk);
      chk({31'h0, wayOut[0]}, {31'h0, way});
      chk({31'h0, (way ? net - n0 : n0 - net) >= 9}, 32'h1);
      host.xfer(1'h1, `SDG_REG_RATE0, 32'h0, rdata);
      repeat (800) @(posedge sysClk);
      host.xfer(1'h0, `SDG_REG_POS0, 32'h0, rdata);
      chk(rdata, net);
      chk(lastHigh, 32'h000000A0);
      chk({31'h0, ledSeen > 0}, 32'h1);
      host.xfer(1'h0, `SDG_REG_POS0 + 8'h04, 32'h0, rdata);
      chk(rdata + others, 32'h0);
    end
  endtask
  // Top rate on channel 2 with one unit high and one low: a step every 160 cycles
  task t_fast;
    begin
      host.xfer(1'h1, `SDG_REG_TIMING, 32'h80010101, rdata);
      host.xfer(1'h1, `SDG_REG_RATE0 + 8'h08, 32'h0199999A, rdata);
      host.xfer(1'h0, `SDG_REG_RATE0 + 8'h08, 32'h0, rdata);
      chk(rdata, 32'h0199999A);
      repeat (1700) @(posedge sysClk);
      chk(lastGap, 32'h000000A0);
      host.xfer(1'h1, `SDG_REG_RATE0 + 8'h08, 32'h0, rdata);
    end
  endtask
  initial begin
    {errors, cmp_count, cycles, net, hiRun, lastHigh, others, ledSeen, gapRun, lastGap} = 320'h0;
    {rst, generalInput, pulsePrev} = 21'h100000;
    repeat (8) @(posedge sysClk);
    rst <= 1'h0;
    @(posedge sysClk);
    t_regs;
    t_io;
    t_step(32'h00A3D70A, 1'h1);
    t_step(32'hFF5C28F6, 1'h0);
    t_fast;
    close_out;
  end
endmodule // tb
bind sdg_top sdg_checker uChk (
  .sysClk(sysClk),
  .rst(rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .generalOutput(generalOutput),
  .pulseOut(pulseOut),
  .wayOut(wayOut),
  .ledOut(ledOut)
);
